//--- rtl/art_map.vh
// register offsets, field positions, reset values and timing counts of the reload timer
`ifndef ART_MAP_VH
`define ART_MAP_VH
// ************************************
// register byte offsets on the bus
// ************************************
`define ART_OFF_CTRL 12'h000
`define ART_OFF_CKCTL 12'h004
`define ART_OFF_IEN 12'h008
`define ART_OFF_CNTL 12'h00c
`define ART_OFF_CNTH 12'h010
`define ART_OFF_RLDL 12'h014
`define ART_OFF_RLDH 12'h018
// ************************************
// control register fields
// ************************************
`define ART_CTL_HOVF 7
`define ART_CTL_LOVF 6
`define ART_CTL_LIEN 5
`define ART_CTL_CAPEN 4
`define ART_CTL_SPLIT 3
`define ART_CTL_RUN 2
`define ART_CTL_XCLK 0
`define ART_CTL_WMASK 8'hfd
// clock control fields
`define ART_CK_HSEL 5
`define ART_CK_LSEL 4
// interrupt enable field
`define ART_IE_TMR 5
`define ART_RST_BYTE 8'h00
// ************************************
// prescale counts
// ************************************
`define ART_DIV_SYS 12
`define ART_DIV_EXT 8
`endif

//--- rtl/art_prescale.v
// divide-by-n tick generator running on the system clock
`timescale 1ns/1ps
`default_nettype none
module art_prescale #(
  parameter DIV = 12
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // tick out
  output reg tick
);
  reg [7:0] cnt_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_q == DIV[7:0] - 8'h01) begin
      cnt_q <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/art_extsync.v
// brings the external oscillator in, divides by 8, and marks its edges
`timescale 1ns/1ps
`default_nettype none
module art_extsync #(
  parameter DIV = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // external oscillator, asynchronous
  input wire extOsc,
  // one-cycle pulses on system clock
  output reg extTick,
  output reg extFall
);
  reg meta_q;
  reg sync_q;
  reg prev_q;
  reg [2:0] div_q;
  // two flops before anything looks at the oscillator
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      div_q <= 3'h0;
      extTick <= 1'b0;
      extFall <= 1'b0;
    end else begin
      meta_q <= extOsc;
      sync_q <= meta_q;
      prev_q <= sync_q;
      extTick <= 1'b0;
      extFall <= 1'b0;
      if (sync_q && !prev_q) begin
        div_q <= div_q + 3'h1;
        if (div_q == DIV[2:0] - 3'h1) begin
          extTick <= 1'b1;
        end
        // the divided clock falls after the fourth rising edge of each eight
        if (div_q == 3'h3) begin
          extFall <= 1'b1; // [R15]
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/art_timer.v
// 16-bit auto-reload timer with split mode and oscillator capture, on an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "art_map.vh"
// Contract
// R1 - count is two readable writable bytes
// R2 - control bit 3 selects split mode
// R3 - system, divided-by-12, synced external-by-8 clocks
// R4 - 16-bit rollover reloads and sets high flag
// R5 - timer enable interrupts every 16-bit overflow
// R6 - low enable adds low-byte wrap interrupts
// R7 - split halves reload from own bytes
// R8 - split: run gates high, low always runs
// R9 - per-half clock select with external select
// R10 - split: each half wrap sets its flag
// R11 - split interrupts: high, or either with low enable
// R12 - flags cleared only by software
// R13 - capture counts system or divided-by-12
// R14 - capture copies count, sets high flag
// R15 - capture on external-by-8 falling edge
// R16 - software keeps 16-bit mode while capturing
// R17 - capture enable bit turns capture on
// R18 - 16-bit mode holds count when stopped
module art_timer (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // external oscillator
  input wire extOsc,
  // interrupt request to the core
  output reg timerIrq
);
  // ************************************
  // clock sources
  // ************************************
  wire sysDivTick;
  wire extTick;
  wire extFall;
  art_prescale #(.DIV(`ART_DIV_SYS)) uPre (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(sysDivTick)
  );
  art_extsync #(.DIV(`ART_DIV_EXT)) uExt (
    .ref_clk(ref_clk),
    .rst(rst),
    .extOsc(extOsc),
    .extTick(extTick),
    .extFall(extFall)
  );
  // ************************************
  // registers
  // ************************************
  reg [7:0] ctrl_q;
  reg [7:0] ckctl_q;
  reg [7:0] ien_q;
  reg [7:0] cntL_q;
  reg [7:0] cntH_q;
  reg [7:0] rldL_q;
  reg [7:0] rldH_q;
  wire splitMode = ctrl_q[`ART_CTL_SPLIT]; // [R2]
  wire runCtl = ctrl_q[`ART_CTL_RUN];
  wire xclkSel = ctrl_q[`ART_CTL_XCLK];
  wire capEn = ctrl_q[`ART_CTL_CAPEN]; // [R17]
  wire lowIrqEn = ctrl_q[`ART_CTL_LIEN];
  wire tmrIrqEn = ien_q[`ART_IE_TMR];
  // per-half tick from select bits
  function tickSel;
    input sysSel;
    input ext;
    input sysTick;
    input divTick;
    input extClk;
    begin
      if (sysSel) begin
        tickSel = sysTick;
      end else if (ext) begin
        tickSel = extClk;
      end else begin
        tickSel = divTick;
      end
    end
  endfunction
  // capture never runs from the oscillator it measures, so xclk is ignored there
  wire capXclk = xclkSel & ~capEn; // [R13]
  wire lowTick = tickSel(ckctl_q[`ART_CK_LSEL], capXclk, 1'b1, sysDivTick, extTick); // [R3] [R9]
  wire highTick = tickSel(ckctl_q[`ART_CK_HSEL], xclkSel, 1'b1, sysDivTick, extTick); // [R9]
  // ************************************
  // count engine
  // ************************************
  // a byte at its top value wraps on its next step
  function isMax;
    input [7:0] v;
    begin
      isMax = (v == 8'hff);
    end
  endfunction
  // one count step of a byte
  function [7:0] bump;
    input [7:0] v;
    begin
      bump = v + 8'h01;
    end
  endfunction
  // in capture mode the count keeps running; only the reload pair is overwritten
  wire capEvt = capEn & extFall; // [R15]
  wire incL = splitMode ? lowTick : (runCtl & lowTick); // [R8] [R18]
  wire incH = splitMode ? (runCtl & highTick) : 1'b0; // [R8]
  wire wrapL = incL & isMax(cntL_q);
  wire wrapH16 = ~splitMode & wrapL & isMax(cntH_q); // [R4]
  wire wrapHsp = incH & isMax(cntH_q); // [R10]
  wire setH = wrapH16 | wrapHsp | capEvt; // [R14]
  wire setL = wrapL;
  // ************************************
  // apb decode
  // ************************************
  wire acc = psel & penable & ~pready;
  // a write lands at the edge where the master sees pready high, never earlier
  wire wr = psel & penable & pready & pwrite;
  wire hitCtl = wr & (paddr == `ART_OFF_CTRL);
  wire hitCk = wr & (paddr == `ART_OFF_CKCTL);
  wire hitIe = wr & (paddr == `ART_OFF_IEN);
  wire hitCnL = wr & (paddr == `ART_OFF_CNTL);
  wire hitCnH = wr & (paddr == `ART_OFF_CNTH);
  wire hitRlL = wr & (paddr == `ART_OFF_RLDL);
  wire hitRlH = wr & (paddr == `ART_OFF_RLDH);
  wire [7:0] wb = pwdata[7:0];
  function mapped;
    input [11:0] a;
    begin
      if (a == `ART_OFF_CTRL) begin
        mapped = 1'b1;
      end else if (a == `ART_OFF_CKCTL) begin
        mapped = 1'b1;
      end else if (a == `ART_OFF_IEN) begin
        mapped = 1'b1;
      end else if (a == `ART_OFF_CNTL) begin
        mapped = 1'b1;
      end else if (a == `ART_OFF_CNTH) begin
        mapped = 1'b1;
      end else if (a == `ART_OFF_RLDL) begin
        mapped = 1'b1;
      end else if (a == `ART_OFF_RLDH) begin
        mapped = 1'b1;
      end else begin
        mapped = 1'b0;
      end
    end
  endfunction
  reg [7:0] rdByte;
  always @* begin
    if (paddr == `ART_OFF_CTRL) begin
      rdByte = ctrl_q;
    end else if (paddr == `ART_OFF_CKCTL) begin
      rdByte = ckctl_q;
    end else if (paddr == `ART_OFF_IEN) begin
      rdByte = ien_q;
    end else if (paddr == `ART_OFF_CNTL) begin
      rdByte = cntL_q; // [R1]
    end else if (paddr == `ART_OFF_CNTH) begin
      rdByte = cntH_q; // [R1]
    end else if (paddr == `ART_OFF_RLDL) begin
      rdByte = rldL_q;
    end else if (paddr == `ART_OFF_RLDH) begin
      rdByte = rldH_q;
    end else begin
      rdByte = 8'h00;
    end
  end
  // one wait state: answer lands one edge after the access phase starts
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped(paddr);
      if (acc & ~pwrite) begin
        prdata <= {24'h00_0000, rdByte};
      end
    end
  end
  // ************************************
  // control, config, reload registers
  // ************************************
  reg [7:0] ctrl_d;
  reg [7:0] rldL_d;
  reg [7:0] rldH_d;
  // hardware set wins over a software clear in the same cycle
  always @* begin
    ctrl_d = ctrl_q;
    if (hitCtl) begin
      // bit 1 has no storage behind it and always reads back zero
      ctrl_d = wb & `ART_CTL_WMASK;
    end
    if (setH) begin
      ctrl_d[`ART_CTL_HOVF] = 1'b1; // [R12]
    end
    if (setL) begin
      ctrl_d[`ART_CTL_LOVF] = 1'b1; // [R12]
    end
  end
  // capture owns the reload pair over a software write
  always @* begin
    rldL_d = rldL_q;
    rldH_d = rldH_q;
    if (capEvt) begin
      rldL_d = cntL_q; // [R14]
      rldH_d = cntH_q; // [R14]
    end else begin
      if (hitRlL) begin
        rldL_d = wb;
      end
      if (hitRlH) begin
        rldH_d = wb;
      end
    end
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `ART_RST_BYTE;
      ckctl_q <= `ART_RST_BYTE;
      ien_q <= `ART_RST_BYTE;
      rldL_q <= `ART_RST_BYTE;
      rldH_q <= `ART_RST_BYTE;
    end else begin
      ctrl_q <= ctrl_d;
      rldL_q <= rldL_d;
      rldH_q <= rldH_d;
      if (hitCk) begin
        ckctl_q <= wb;
      end
      if (hitIe) begin
        ien_q <= wb;
      end
    end
  end
  // ************************************
  // count bytes
  // ************************************
  // reading low then high can tear while running; stop the timer for a coherent pair
  reg [7:0] cntL_d;
  reg [7:0] cntH_d;
  // a software write to a byte overrides its count step
  always @* begin
    cntL_d = cntL_q;
    if (hitCnL) begin
      cntL_d = wb; // [R1]
    end else if (wrapH16 | (splitMode & wrapL)) begin
      cntL_d = rldL_q; // [R4] [R7]
    end else if (incL) begin
      // a 16-bit low wrap steps on to zero and carries into the high byte
      cntL_d = bump(cntL_q);
    end
  end
  always @* begin
    cntH_d = cntH_q;
    if (hitCnH) begin
      cntH_d = wb; // [R1]
    end else if (wrapH16) begin
      cntH_d = rldH_q; // [R4]
    end else if (~splitMode & wrapL) begin
      cntH_d = bump(cntH_q);
    end else if (wrapHsp) begin
      cntH_d = rldH_q; // [R7]
    end else if (incH) begin
      cntH_d = bump(cntH_q);
    end
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cntL_q <= `ART_RST_BYTE;
      cntH_q <= `ART_RST_BYTE;
    end else begin
      cntL_q <= cntL_d;
      cntH_q <= cntH_d;
    end
  end
  // ************************************
  // interrupt request
  // ************************************
  // level from the sticky flags, so it stays up until software clears them
  wire irqHigh = ctrl_q[`ART_CTL_HOVF]; // [R5] [R11]
  wire irqLow = lowIrqEn & ctrl_q[`ART_CTL_LOVF]; // [R6] [R11]
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= tmrIrqEn & (irqHigh | irqLow); // [R5]
    end
  end
endmodule
`default_nettype wire

//--- bench/art_timer_checker.sv
// assertion checker for the reload timer bus slave and interrupt line
`timescale 1ns/1ps
`default_nettype none
module art_timer_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // oscillator and interrupt
  input wire logic extOsc,
  input wire logic timerIrq
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access accepted");
  a_no_err_mapped: assert property (pready && paddr <= 12'h018 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_irq_drop: assert property ($fell(timerIrq) |-> $past(pready && pwrite, 2))
    else $error("irq dropped without write");
  c_read: cover property (pready && !pwrite);
  c_unmapped: cover property (pslverr);
  c_irq: cover property ($rose(timerIrq));
endmodule
`default_nettype wire

//--- bench/art_osc_model.sv
// free-running external oscillator outside the timer
`timescale 1ns/1ps
`default_nettype none
module art_osc_model #(
  parameter real HALF_NS = 130.0
) (
  // oscillator pin
  output logic extOsc
);
  // odd start offset keeps it out of phase with the system clock; /8 falls drive capture
  initial begin
    extOsc = 1'b0;
    #7.3;
    forever #(HALF_NS) extOsc = ~extOsc;
  end
endmodule
`default_nettype wire

//--- bench/test_art_timer.sv
// self-checking bench for the reload timer over apb
`timescale 1ns/1ps
`default_nettype none
`include "art_map.vh"
module test_art_timer;
  logic ref_clk, rst, psel, penable, pwrite, extOsc, pready, pslverr, timerIrq, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, cap;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  art_timer dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extOsc(extOsc), .timerIrq(timerIrq));
  art_osc_model osc (.extOsc(extOsc));
  // ****
  // clock, timeout, report
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ****
  // apb master
  // ****
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, {24'h0, exp}, rv);
    chk({what, " err"}, 32'h0, {31'h0, ev});
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++) rd("reset value", 12'(i * 4), 8'h00);
    apb(1'b0, 12'h01c, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, ev});
    apb(1'b1, `ART_OFF_CNTL, 8'hfe);
    apb(1'b1, `ART_OFF_CNTH, 8'hff);
    repeat (30) @(posedge ref_clk);
    rd("held low", `ART_OFF_CNTL, 8'hfe);
    rd("held high", `ART_OFF_CNTH, 8'hff);
    apb(1'b1, `ART_OFF_RLDL, 8'h34);
    apb(1'b1, `ART_OFF_RLDH, 8'h12);
    apb(1'b1, `ART_OFF_CKCTL, 8'h30);
    apb(1'b1, `ART_OFF_IEN, 8'h20);
    apb(1'b1, `ART_OFF_CTRL, 8'h04);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, `ART_OFF_CTRL, 8'h00);
    chk("16-bit flag", 32'h84, rv & 32'hffffffbf);
    rd("reloaded high", `ART_OFF_CNTH, 8'h12);
    chk("16-bit irq", 32'h1, {31'h0, timerIrq});
    repeat (300) @(posedge ref_clk);
    apb(1'b0, `ART_OFF_CTRL, 8'h00);
    chk("flag kept", 32'h84, rv & 32'hffffffbf);
    apb(1'b1, `ART_OFF_CTRL, 8'h24);
    repeat (300) @(posedge ref_clk);
    rd("low wrap flag", `ART_OFF_CTRL, 8'h64);
    chk("low wrap irq", 32'h1, {31'h0, timerIrq});
    apb(1'b1, `ART_OFF_CTRL, 8'h08);
    apb(1'b1, `ART_OFF_RLDL, 8'hf0);
    apb(1'b1, `ART_OFF_CNTL, 8'hf8);
    apb(1'b1, `ART_OFF_CNTH, 8'h77);
    repeat (40) @(posedge ref_clk);
    rd("split flags", `ART_OFF_CTRL, 8'h48);
    rd("split high", `ART_OFF_CNTH, 8'h77);
    apb(1'b0, `ART_OFF_CNTL, 8'h00);
    chk("split low", 32'hf, {28'h0, rv[7:4]});
    rd("no capture", `ART_OFF_RLDL, 8'hf0);
    chk("split no irq", 32'h0, {31'h0, timerIrq});
    apb(1'b1, `ART_OFF_CTRL, 8'h28);
    repeat (40) @(posedge ref_clk);
    chk("split low irq", 32'h1, {31'h0, timerIrq});
    apb(1'b1, `ART_OFF_CKCTL, 8'h10);
    apb(1'b1, `ART_OFF_CNTL, 8'h00);
    apb(1'b1, `ART_OFF_CNTH, 8'h00);
    apb(1'b1, `ART_OFF_CTRL, 8'h14);
    repeat (400) @(posedge ref_clk);
    apb(1'b0, `ART_OFF_CTRL, 8'h00);
    chk("capture flag", 32'h94, rv & 32'hffffffbf);
    apb(1'b1, `ART_OFF_CTRL, 8'h04);
    apb(1'b0, `ART_OFF_RLDL, 8'h00);
    cap = rv;
    apb(1'b0, `ART_OFF_RLDH, 8'h00);
    cap = cap | (rv << 8);
    chk("capture value", 32'h1, 32'(cap >= 256 && cap <= 420));
    apb(1'b1, `ART_OFF_CKCTL, 8'h00);
    apb(1'b1, `ART_OFF_CTRL, 8'h0c);
    apb(1'b1, `ART_OFF_CNTH, 8'h00);
    repeat (240) @(posedge ref_clk);
    apb(1'b0, `ART_OFF_CNTH, 8'h00);
    chk("div12 count", 32'h1, 32'(rv >= 19 && rv <= 22));
    apb(1'b1, `ART_OFF_CTRL, 8'h0d);
    apb(1'b1, `ART_OFF_CNTH, 8'h00);
    repeat (520) @(posedge ref_clk);
    apb(1'b0, `ART_OFF_CNTH, 8'h00);
    chk("ext8 count", 32'h1, 32'(rv >= 4 && rv <= 6));
    wrap_up();
  end
endmodule
bind art_timer art_timer_checker chk_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .extOsc(extOsc), .timerIrq(timerIrq));
`default_nettype wire
